// ---- logic/ssrc_pkg.sv ----
// shared constants of the sweep status and restart controller
package ssrc_pkg;
   // ==========================================================
   // clocks and the restart sequencer
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned RESTART_HZ = 512_000;
   localparam int unsigned RESTART_DIV = CLK_HZ / RESTART_HZ; // 488 system clocks per restart tick
   localparam int unsigned DIV_W = 9;
   localparam logic [3:0] SEQ_RESET_CNT = 4'h2;
   localparam logic [3:0] SEQ_START_CNT = 4'h5;
   localparam logic [3:0] SEQ_SELFOFF_CNT = 4'h8;
   localparam logic [3:0] SEQ_LAST_CNT = 4'h9;

   // ==========================================================
   // register map, byte addresses
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] VALUE_OFS = 8'h08;
   localparam logic [7:0] RATE_OFS = 8'h0c;

   // control bits, write one to fire a single pulse
   localparam int unsigned CTRL_RESET_BIT = 0;
   localparam int unsigned CTRL_GO_BIT = 1;
   localparam int unsigned CTRL_HOLD_BIT = 2;

   // status bits
   localparam int unsigned ST_RUN_BIT = 0;
   localparam int unsigned ST_HOLD_BIT = 1;
   localparam int unsigned ST_EOS_BIT = 2;
   localparam int unsigned ST_RESTART_BIT = 3;
   localparam int unsigned ST_GATE_BIT = 4;
   localparam int unsigned ST_UP_BIT = 5;
   localparam int unsigned ST_DOWN_BIT = 6;
   localparam int unsigned ST_HOLDLED_BIT = 7;
   localparam int unsigned ST_ENDLED_BIT = 8;
   localparam int unsigned ST_RELAY_BIT = 9;

   // ==========================================================
   // reset values and widths
   localparam int unsigned VALUE_W = 12;
   localparam int unsigned RATE_W = 16;
   localparam logic [11:0] SWEEP_START = 12'h7ff;
   localparam logic [15:0] RATE_RST = 16'h00ff;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ---- logic/ssrc_sync.sv ----
// two-stage synchroniser with rising-edge pulse for a group of pins
`timescale 1ns/10ps
module ssrc_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous inputs
   input wire logic [W-1:0] async_in,
   // synchronised level and one-cycle rise
   output logic [W-1:0] level,
   output logic [W-1:0] rise
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } ssrc_sync_t;

   ssrc_sync_t q, d;

   generate
      if (W < 1) begin : g_chk
         $error("ssrc_sync: W must be at least 1");
      end
   endgenerate

   // ==========================================================
   // next state, s1 feeds only s2
   always_comb begin
      d = q;
      d.s1 = async_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // edge detect on the settled stages only
   assign level = q.s2;
   assign rise = q.s2 & ~q.s3;
endmodule // ssrc_sync

// ---- logic/ssrc_restart_seq.sv ----
// decade restart sequencer on a 512 kHz tick derived from the system clock
`timescale 1ns/10ps
module ssrc_restart_seq #(
   parameter int unsigned DIV = ssrc_pkg::RESTART_DIV
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // count enable, low lets the counter run
   input wire logic count_en_n,
   // decoded pulses, each one restart tick long
   output logic reset_p,
   output logic start_p,
   output logic selfoff_p,
   // one-cycle pulse at the end of the self-turnoff period
   output logic selfoff_done
);
   typedef struct packed {
      logic [ssrc_pkg::DIV_W-1:0] div;
      logic [3:0] cnt;
      logic done;
   } ssrc_seq_t;

   ssrc_seq_t q, d;
   logic tick;

   generate
      if (DIV < 2 || DIV > (1 << ssrc_pkg::DIV_W)) begin : g_chk
         $error("ssrc_restart_seq: DIV out of range");
      end
   endgenerate

   assign tick = (q.div == ssrc_pkg::DIV_W'(DIV - 1));

   // ==========================================================
   // prescaler and decade counter
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.div = tick ? '0 : q.div + 1'b1;
      if (!count_en_n && tick) begin
         if (q.cnt == ssrc_pkg::SEQ_SELFOFF_CNT) begin
            d.cnt = 4'h0; // stop and rewind
            d.done = 1'b1;
         end else if (q.cnt == ssrc_pkg::SEQ_LAST_CNT) begin
            d.cnt = 4'h0;
         end else begin
            d.cnt = q.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // decoded pulses at distinct rising counts
   assign reset_p = !count_en_n && (q.cnt == ssrc_pkg::SEQ_RESET_CNT);
   assign start_p = !count_en_n && (q.cnt == ssrc_pkg::SEQ_START_CNT);
   assign selfoff_p = !count_en_n && (q.cnt == ssrc_pkg::SEQ_SELFOFF_CNT);
   assign selfoff_done = q.done;
endmodule // ssrc_restart_seq

// ---- logic/ssrc_top.sv ----
// sweep status indicators, marker relay, ramp value and continuous restart control
//
// Summary of operation
// - with sweep enabled, up lamp on direction up, down lamp on direction down.
// - hold press sets hold flag; hold lamp follows that flag.
// - go press clears the hold flag and darkens the hold lamp.
// - termination term high sets end flag and lights the end lamp.
// - any reset darkens every status lamp.
// - at most one of up, down and hold lamps lit; end lamp can be lit together with the hold lamp.
// - marker relay on only with marker switch enabled and sweep enabled.
// - termination term high marks end of sweep, setting end flag.
// - end flag setting in continuous mode sets the restart flag.
// - restart counter is decade, stepping at 512 kHz.
// - restart counter enable is active low; high halts counting.
// - sequence gives reset, then start (as go), then self-turnoff clearing restart.
// - sequence repeats after every sweep while continuous mode is selected.
// - single mode at sweep end clears restart flag, counter stays inhibited.
// - a 12-bit value ramps linearly in time toward the converter.
// - sweep enable needs function selected, end flag clear, run flag set.
// - direction high means up, low means down.
// - reset comes from power-on, sequencer reset pulse, reset button, or a bus write of the control reset bit.
`timescale 1ns/10ps
module ssrc_top #(
   parameter int unsigned RESTART_DIV = ssrc_pkg::RESTART_DIV
) (
   // clock and power-on reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // operator pushbuttons
   input wire logic go_btn,
   input wire logic hold_btn,
   input wire logic reset_btn,
   // operator switches
   input wire logic fn_selected,
   input wire logic repeat_cont,
   input wire logic marker_en_sw,
   // levels from the sweep counter logic
   input wire logic count_dir,
   input wire logic sweep_terminate_term,
   // indicators and relay
   output logic up_led,
   output logic down_led,
   output logic hold_led,
   output logic end_led,
   output logic recorder_marker_relay,
   // sweep outputs
   output logic sweep_enable_gate,
   output logic sweep_reset_out,
   output logic [11:0] sweep_value
);
   typedef struct packed {
      logic run_flag;
      logic hold_flag;
      logic end_of_sweep_flag;
      logic eos_prev;
      logic restart_flag;
      logic gate;
      logic up;
      logic down;
      logic hold_l;
      logic end_l;
      logic relay;
      logic sreset;
      logic [11:0] value;
      logic [15:0] rate;
      logic [15:0] step_cnt;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
   } ssrc_state_t;

   ssrc_state_t q, d;

   // synchronised pins
   logic [2:0] btn_lvl;
   logic [2:0] btn_rise;
   logic [4:0] sw_lvl;
   logic go_p;
   logic hold_p;
   logic reset_p;

   // sequencer pulses
   logic restart_reset_pulse;
   logic restart_start_pulse;
   logic restart_selfoff_pulse;
   logic seq_done;

   // bus decode
   logic addr_ok;
   logic [7:0] ap_addr;
   logic soft_reset;
   logic soft_go;
   logic soft_hold;

   // combined events
   logic sweep_reset;
   logic go_ev;
   logic hold_ev;
   logic sweep_en;
   logic eos_rise;
   logic [31:0] status_w;

   generate
      if (RESTART_DIV < 2) begin : g_chk
         $error("ssrc_top: RESTART_DIV too small");
      end
   endgenerate

   // ==========================================================
   // input synchronisers
   ssrc_sync #(.W(3)) u_btn_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .async_in({reset_btn, hold_btn, go_btn}),
      .level(btn_lvl),
      .rise(btn_rise)
   );

   ssrc_sync #(.W(5)) u_sw_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .async_in({sweep_terminate_term, count_dir, marker_en_sw, repeat_cont, fn_selected}),
      .level(sw_lvl),
      .rise()
   );

   assign go_p = btn_rise[0];
   assign hold_p = btn_rise[1];
   assign reset_p = btn_rise[2];

   // ==========================================================
   // continuous restart sequencer
   ssrc_restart_seq #(.DIV(RESTART_DIV)) u_seq (
      .clk(hclk),
      .rst_n(hresetn),
      .count_en_n(~q.restart_flag),
      .reset_p(restart_reset_pulse),
      .start_p(restart_start_pulse),
      .selfoff_p(restart_selfoff_pulse),
      .selfoff_done(seq_done)
   );

   // ==========================================================
   // bus decode and write-one pulses
   assign ap_addr = haddr[7:0];
   assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
   assign soft_reset = q.wr_pend && (q.wr_addr == ssrc_pkg::CTRL_OFS) && hwdata[ssrc_pkg::CTRL_RESET_BIT];
   assign soft_go = q.wr_pend && (q.wr_addr == ssrc_pkg::CTRL_OFS) && hwdata[ssrc_pkg::CTRL_GO_BIT];
   assign soft_hold = q.wr_pend && (q.wr_addr == ssrc_pkg::CTRL_OFS) && hwdata[ssrc_pkg::CTRL_HOLD_BIT];

   // reset sources besides power-on
   assign sweep_reset = reset_p | restart_reset_pulse | soft_reset;
   // a hold in the same cycle beats go so that lamps stay exclusive
   assign hold_ev = hold_p | soft_hold;
   assign go_ev = (go_p | soft_go) & ~hold_ev;

   // enable gate from function, end flag and run flag
   assign sweep_en = sw_lvl[0] & ~q.end_of_sweep_flag & q.run_flag;
   assign eos_rise = q.end_of_sweep_flag & ~q.eos_prev;

   // status word
   always_comb begin
      status_w = 32'h00000000;
      status_w[ssrc_pkg::ST_RUN_BIT] = q.run_flag;
      status_w[ssrc_pkg::ST_HOLD_BIT] = q.hold_flag;
      status_w[ssrc_pkg::ST_EOS_BIT] = q.end_of_sweep_flag;
      status_w[ssrc_pkg::ST_RESTART_BIT] = q.restart_flag;
      status_w[ssrc_pkg::ST_GATE_BIT] = q.gate;
      status_w[ssrc_pkg::ST_UP_BIT] = q.up;
      status_w[ssrc_pkg::ST_DOWN_BIT] = q.down;
      status_w[ssrc_pkg::ST_HOLDLED_BIT] = q.hold_l;
      status_w[ssrc_pkg::ST_ENDLED_BIT] = q.end_l;
      status_w[ssrc_pkg::ST_RELAY_BIT] = q.relay;
   end

   // ==========================================================
   // next state
   always_comb begin
      d = q;

      // run flag: go or sequencer start sets, hold or reset clears
      if (sweep_reset || hold_ev) begin
         d.run_flag = 1'b0;
      end
      if (go_ev || restart_start_pulse) begin
         d.run_flag = 1'b1;
      end

      // hold flag
      if (go_ev || sweep_reset) begin
         d.hold_flag = 1'b0;
      end
      if (hold_ev) begin
         d.hold_flag = 1'b1;
      end

      // end-of-sweep flag, set wins over reset
      if (sweep_reset) begin
         d.end_of_sweep_flag = 1'b0;
      end
      if (sw_lvl[4]) begin
         d.end_of_sweep_flag = 1'b1;
      end
      d.eos_prev = q.end_of_sweep_flag;

      // restart flag: decided when the end flag sets, cleared by self-turnoff
      if (seq_done) begin
         d.restart_flag = 1'b0;
      end
      if (eos_rise) begin
         d.restart_flag = sw_lvl[1];
      end

      // indicators, all dark while a reset is active
      d.gate = sweep_en & ~sweep_reset;
      d.up = sweep_en & sw_lvl[3] & ~sweep_reset;
      d.down = sweep_en & ~sw_lvl[3] & ~sweep_reset;
      d.hold_l = q.hold_flag & ~sweep_en & ~sweep_reset;
      d.end_l = q.end_of_sweep_flag & ~sweep_reset;
      d.relay = sw_lvl[2] & sweep_en & ~sweep_reset;
      d.sreset = sweep_reset;

      // linear ramp, one step per rate+1 clocks
      if (sweep_reset) begin
         d.value = ssrc_pkg::SWEEP_START;
         d.step_cnt = 16'h0000;
      end else if (sweep_en) begin
         if (q.step_cnt >= q.rate) begin
            d.step_cnt = 16'h0000;
            d.value = sw_lvl[3] ? q.value + 12'h001 : q.value - 12'h001;
         end else begin
            d.step_cnt = q.step_cnt + 16'h0001;
         end
      end

      // bus data phase write
      d.wr_pend = 1'b0;
      if (q.wr_pend && (q.wr_addr == ssrc_pkg::RATE_OFS)) begin
         d.rate = hwdata[15:0];
      end

      // bus address phase, zero wait states
      d.ready = 1'b1;
      if (hsel && hready && (htrans == ssrc_pkg::HTRANS_NONSEQ || htrans == ssrc_pkg::HTRANS_SEQ)) begin
         d.wr_pend = hwrite & addr_ok;
         d.wr_addr = ap_addr;
         d.rdata = 32'h00000000;
         if (!hwrite && addr_ok) begin
            case (ap_addr)
               ssrc_pkg::STATUS_OFS: begin
                  d.rdata = status_w;
               end
               ssrc_pkg::VALUE_OFS: begin
                  d.rdata = {20'h00000, q.value};
               end
               ssrc_pkg::RATE_OFS: begin
                  d.rdata = {16'h0000, q.rate};
               end
               default: begin
                  d.rdata = 32'h00000000;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.value <= ssrc_pkg::SWEEP_START;
         q.rate <= ssrc_pkg::RATE_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs, straight from flops except hresp, tied low
   assign hrdata = q.rdata;
   assign hreadyout = q.ready;
   assign hresp = 1'b0;
   assign up_led = q.up;
   assign down_led = q.down;
   assign hold_led = q.hold_l;
   assign end_led = q.end_l;
   assign recorder_marker_relay = q.relay;
   assign sweep_enable_gate = q.gate;
   assign sweep_reset_out = q.sreset;
   assign sweep_value = q.value;
endmodule // ssrc_top

// ---- dv/ssrc_top_monitor.sv ----
// assertion checker on the ports of the sweep status and restart controller
`timescale 1ns/10ps
module ssrc_top_monitor #(
   parameter int unsigned RESTART_DIV = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // operator levels
   input wire logic fn_selected,
   input wire logic repeat_cont,
   input wire logic marker_en_sw,
   input wire logic count_dir,
   // lamps, relay and sweep control
   input wire logic up_led,
   input wire logic down_led,
   input wire logic hold_led,
   input wire logic end_led,
   input wire logic recorder_marker_relay,
   input wire logic sweep_enable_gate,
   input wire logic sweep_reset_out
);
   // ==========================================================
   // restart sequence steps
   localparam int SEQ_GAP = 4 * RESTART_DIV + 8;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence end_cont_s;
      repeat_cont[*8] ##0 $rose(end_led);
   endsequence
   sequence rst_then_go_s;
      ##[1:SEQ_GAP] $rose(sweep_reset_out) ##[1:SEQ_GAP] $rose(sweep_enable_gate);
   endsequence

   // ==========================================================
   // lamp, relay and sequencer relations
   lamps_onehot_a: assert property ($onehot0({up_led, down_led, hold_led, end_led}))
      else $error("more than one lamp lit");
   dir_lamp_a: assert property ($stable(count_dir)[*7] ##0 (sweep_enable_gate && !sweep_reset_out)
      |-> up_led == count_dir && down_led == !count_dir) else $error("direction lamp wrong");
   relay_gate_a: assert property (recorder_marker_relay |-> sweep_enable_gate)
      else $error("relay on without sweep enable");
   marker_off_a: assert property ((!marker_en_sw)[*7] |-> !recorder_marker_relay)
      else $error("relay on with marker switch off");
   fn_gate_a: assert property ((!fn_selected)[*7] |-> !sweep_enable_gate)
      else $error("sweep enabled with no function");
   end_stop_a: assert property (end_led |-> !sweep_enable_gate)
      else $error("sweep enabled after end");
   hold_stop_a: assert property (hold_led |-> !sweep_enable_gate)
      else $error("sweep enabled while held");
   reset_dark_a: assert property (sweep_reset_out ##1 sweep_reset_out |->
      !(up_led || down_led || hold_led || end_led)) else $error("lamp lit during reset");
   restart_seq_a: assert property (end_cont_s |-> rst_then_go_s)
      else $error("restart did not reset then start");
   bus_okay_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
      else $error("bus not ready or not okay");
endmodule // ssrc_top_monitor

bind ssrc_top ssrc_top_monitor #(.RESTART_DIV(RESTART_DIV)) mon_u (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .fn_selected(fn_selected), .repeat_cont(repeat_cont), .marker_en_sw(marker_en_sw),
   .count_dir(count_dir), .up_led(up_led), .down_led(down_led), .hold_led(hold_led),
   .end_led(end_led), .recorder_marker_relay(recorder_marker_relay),
   .sweep_enable_gate(sweep_enable_gate), .sweep_reset_out(sweep_reset_out)
);

// ---- dv/ssrc_panel.sv ----
// operator panel model: one-cycle press requests become held button levels
`timescale 1ns/10ps
module ssrc_panel #(
   parameter logic [3:0] PRESS_CYC = 4'h6
) (
   // clock
   input wire logic hclk,
   // press requests: go, hold, reset
   input wire logic [2:0] press_req,
   // buttons, high while pressed
   output logic [2:0] btn
);
   logic [3:0] left_q [3] = '{default: 4'h0};
   // a press stays down for several clocks, as a finger would
   always @(posedge hclk) begin
      for (int i = 0; i < 3; i++) begin
         if (press_req[i]) begin
            left_q[i] <= PRESS_CYC;
         end else if (left_q[i] != 4'h0) begin
            left_q[i] <= left_q[i] - 4'h1;
         end
      end
   end
   // button level
   assign btn = {left_q[2] != 4'h0, left_q[1] != 4'h0, left_q[0] != 4'h0};
endmodule // ssrc_panel

// ---- dv/sweep_status_restart_ctrl_bench.sv ----
// self-checking bench for the sweep status and restart controller
`timescale 1ns/10ps
module sweep_status_restart_ctrl_bench;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, got, rate;
   logic [1:0] htrans;
   logic [2:0] hsize, press_req, btn;
   logic fn_selected, repeat_cont, marker_en_sw, count_dir, term;
   logic up_led, down_led, hold_led, end_led, relay, gate, rst_out;
   logic [11:0] sweep_value;
   logic [31:0] exp_q [$];
   int n_fail = 0;
   int cmp_count = 0;
   event seen;

   // ==========================================================
   // design, panel and clock
   always_comb hready = hreadyout;
   ssrc_top #(.RESTART_DIV(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .go_btn(btn[0]), .hold_btn(btn[1]),
      .reset_btn(btn[2]), .fn_selected(fn_selected), .repeat_cont(repeat_cont),
      .marker_en_sw(marker_en_sw), .count_dir(count_dir), .sweep_terminate_term(term),
      .up_led(up_led), .down_led(down_led), .hold_led(hold_led), .end_led(end_led),
      .recorder_marker_relay(relay), .sweep_enable_gate(gate), .sweep_reset_out(rst_out),
      .sweep_value(sweep_value));
   ssrc_panel panel_u (.hclk(hclk), .press_req(press_req), .btn(btn));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // ==========================================================
   // checking and closing
   task check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      cmp_count++;
      if (seen_v !== exp_v) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // oldest note against each read result
   initial begin
      forever begin
         @(seen);
         check(got, exp_q.pop_front());
      end
   end

   // ==========================================================
   // bus and panel tasks
   task automatic wait_hi(ref logic s);
      int i;
      i = 0;
      @(posedge hclk);
      while (s !== 1'b1 && i < 300) begin
         @(posedge hclk);
         i++;
      end
      if (i >= 300) begin
         n_fail++;
         wrap_up;
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= ssrc_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_hi(hready);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_hi(hready);
      got = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
      -> seen;
   endtask
   task press(input int b);
      @(posedge hclk);
      press_req[b] <= 1'b1;
      @(posedge hclk);
      press_req <= 3'h0;
      repeat (12) @(posedge hclk);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; press_req = 3'h0; fn_selected = 1'b1; repeat_cont = 1'b0;
      marker_en_sw = 1'b1; count_dir = 1'b1; term = 1'b0;
      void'($urandom(32'hc692));
      rate = {16'h0, 16'($urandom)};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ssrc_pkg::STATUS_OFS, 32'h0);
      rd(ssrc_pkg::VALUE_OFS, 32'h7ff);
      rd(ssrc_pkg::RATE_OFS, 32'hff);
      bus(1'b1, ssrc_pkg::RATE_OFS, rate);
      rd(ssrc_pkg::RATE_OFS, rate);
      rd(8'h10, 32'h0);
      press(0);
      rd(ssrc_pkg::STATUS_OFS, 32'h231);
      count_dir <= 1'b0;
      repeat (12) @(posedge hclk);
      rd(ssrc_pkg::STATUS_OFS, 32'h251);
      marker_en_sw <= 1'b0;
      repeat (12) @(posedge hclk);
      rd(ssrc_pkg::STATUS_OFS, 32'h051);
      press(1);
      rd(ssrc_pkg::STATUS_OFS, 32'h082);
      press(0);
      rd(ssrc_pkg::STATUS_OFS, 32'h051);
      // no function selected: run stays, gate and lamps drop
      fn_selected <= 1'b0;
      repeat (12) @(posedge hclk);
      rd(ssrc_pkg::STATUS_OFS, 32'h001);
      fn_selected <= 1'b1;
      term <= 1'b1;
      repeat (12) @(posedge hclk);
      rd(ssrc_pkg::STATUS_OFS, 32'h105);
      term <= 1'b0;
      press(2);
      rd(ssrc_pkg::STATUS_OFS, 32'h0);
      rd(ssrc_pkg::VALUE_OFS, 32'h7ff);
      // ramp output pin back at its start value
      @(posedge hclk);
      exp_q.push_back(32'h7ff);
      got = {20'h0, sweep_value};
      -> seen;
      // continuous mode, started by a bus go, two sweeps in a row
      repeat_cont <= 1'b1;
      marker_en_sw <= 1'b1;
      bus(1'b1, ssrc_pkg::CTRL_OFS, 32'h2);
      repeat (12) @(posedge hclk);
      rd(ssrc_pkg::STATUS_OFS, 32'h251);
      for (int k = 0; k < 2; k++) begin
         term <= 1'b1;
         wait_hi(end_led);
         term <= 1'b0; // end flag keeps the event; drop early so the restart reset clears it
         rd(ssrc_pkg::STATUS_OFS, 32'h10d);
         wait_hi(rst_out);
         repeat (60) @(posedge hclk);
         rd(ssrc_pkg::STATUS_OFS, 32'h251);
      end
      // let the checker take the last note before closing
      repeat (2) @(posedge hclk);
      wrap_up;
   end
endmodule // sweep_status_restart_ctrl_bench
